// ==== bench/pms_mode_lamp_assertions.sv ====
// concurrent checks of the mode/lamp block, bound to its top
// assumes pms_consts.svh on the include path
`include "pms_consts.svh"
module pms_mode_lamp_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic              mclk_in, arst_n_in, psel_in, penable_in,
  input wire logic              pwrite_in, pready_out, pslverr_out,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0]       pwdata_in, prdata_out,
  input wire logic [3:0]        pstrb_in,
  input wire logic              link10_indicator_n_in,
  input wire logic              full_duplex_indicator_n_in,
  input wire logic              txrx_activity_indicator_n_in,
  input wire logic              link100_indicator_n_in,
  input wire logic              rx_activity_indicator_n_in,
  input wire logic              tx_activity_indicator_n_in,
  input wire logic              mac_autoneg_select_speed_100_in, mac_autoneg_select_full_duplex_in,
  input wire logic              phy_speed_100_out, phy_full_duplex_out,
  input wire logic              phy_autoneg_mode_out,
  input wire logic              first_lamp_output, second_lamp_output
);
  logic [15:0] rpc_r, phyc_r, bm;
  logic [5:0]  act;
  logic [1:0]  up_r;
  logic        acc, hit, both;
  assign acc  = psel_in & penable_in;
  assign bm   = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
  assign both = rpc_r[11] & phyc_r[12];
  assign act  = ~{tx_activity_indicator_n_in, rx_activity_indicator_n_in,
                  link100_indicator_n_in, txrx_activity_indicator_n_in,
                  full_duplex_indicator_n_in, link10_indicator_n_in};
  assign hit  = paddr_in == {`PMS_RPC_IDX, 2'h0} ||
                paddr_in == {`PMS_PHYC_IDX, 2'h0} ||
                paddr_in == {`PMS_STAT_IDX, 2'h0};
  function automatic logic lamp(logic [2:0] c, logic [5:0] a);
    case (c)
      3'h0:    return a[3] | a[0];
      3'h2:    return a[0];
      3'h3:    return a[1];
      3'h4:    return a[2];
      3'h5:    return a[3];
      3'h6:    return a[4];
      3'h7:    return a[5];
      default: return 1'b0;
    endcase
  endfunction : lamp
  // shadow copies so outputs can be tied to what software wrote
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rpc_r  <= `PMS_RPC_RST;
      phyc_r <= `PMS_PHYC_RST;
    end else if (acc && pwrite_in) begin
      if (paddr_in == {`PMS_RPC_IDX, 2'h0})
        rpc_r <= (rpc_r & ~bm) | (pwdata_in[15:0] & bm & `PMS_RPC_WMASK);
      if (paddr_in == {`PMS_PHYC_IDX, 2'h0})
        phyc_r <= (phyc_r & ~bm) | (pwdata_in[15:0] & bm & `PMS_PHYC_WMASK);
    end
  end
  // syncers hide pin history for three edges after reset
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  a_mac_manual: assert property (up_r == 2'h3 && !$past(rpc_r[11]) |->
    phy_speed_100_out == $past(rpc_r[13]) &&
    phy_full_duplex_out == $past(rpc_r[12])) else $error("mac mode wrong");
  a_phy_manual: assert property (up_r == 2'h3 &&
    $past(rpc_r[11] & !phyc_r[12]) |-> phy_speed_100_out == $past(phyc_r[13])
    && phy_full_duplex_out == $past(phyc_r[8])) else $error("phy mode wrong");
  a_neg_flag: assert property (up_r == 2'h3 |->
    phy_autoneg_mode_out == $past(both)) else $error("neg flag wrong");
  a_neg_follow: assert property (up_r == 2'h3 && $past(both) |->
    phy_speed_100_out == $past(mac_autoneg_select_speed_100_in, 3) &&
    phy_full_duplex_out == $past(mac_autoneg_select_full_duplex_in, 3))
    else $error("neg result wrong");
  a_lamp_a_src: assert property (up_r == 2'h3 |->
    first_lamp_output == lamp($past(rpc_r[7:5]), $past(act, 3)))
    else $error("lamp a wrong");
  a_lamp_b_src: assert property (up_r == 2'h3 |->
    second_lamp_output == lamp($past(rpc_r[4:2]), $past(act, 3)))
    else $error("lamp b wrong");
  a_unmapped_err: assert property (acc && !hit |->
    pslverr_out && (pwrite_in || prdata_out == 32'h0))
    else $error("unmapped not refused");
  a_mapped_ok: assert property (acc && hit |-> !pslverr_out && (pwrite_in
    || prdata_out[31:16] == 16'h0)) else $error("mapped access bad");
  a_zero_wait: assert property (psel_in && !penable_in ##1 acc |->
    pready_out) else $error("access not ready");
  c_neg: cover property (phy_autoneg_mode_out);
  c_err: cover property (acc && pslverr_out);
  c_lamp: cover property (first_lamp_output && !second_lamp_output);
endmodule : pms_mode_lamp_chk

bind pms_mode_lamp pms_mode_lamp_chk #(.ADDR_W(ADDR_W)) u_chk (
  .mclk_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in, .pready_out,
  .pslverr_out, .paddr_in, .pwdata_in, .prdata_out, .pstrb_in,
  .link10_indicator_n_in, .full_duplex_indicator_n_in,
  .txrx_activity_indicator_n_in, .link100_indicator_n_in,
  .rx_activity_indicator_n_in, .tx_activity_indicator_n_in,
  .mac_autoneg_select_speed_100_in, .mac_autoneg_select_full_duplex_in, .phy_speed_100_out,
  .phy_full_duplex_out, .phy_autoneg_mode_out, .first_lamp_output,
  .second_lamp_output);

// ==== bench/pms_mode_lamp_tb.sv ====
// self-checking bench of the mode/lamp block over APB
// assumes design, checker and phy model compiled before it
`include "pms_consts.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, e, s); end end
module pms_mode_lamp_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pms_pkg::*;
  localparam logic [11:0] RPC = {`PMS_RPC_IDX, 2'h0};
  localparam logic [11:0] PHC = {`PMS_PHYC_IDX, 2'h0};
  localparam logic [11:0] STA = {`PMS_STAT_IDX, 2'h0};
  logic        mclk_in, arst_n_in, psel_in, penable_in, pwrite_in;
  logic        pready_out, pslverr_out, e, spd, fdx, a_spd, a_fdx;
  logic        phy_speed_100_out, phy_full_duplex_out, phy_autoneg_mode_out;
  logic        first_lamp_output, second_lamp_output;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, q;
  logic [3:0]  pstrb_in;
  logic [5:0]  act, ind_n;
  int          fails, n_tests, cyc;

  pms_phy_model u_phy (.act_in(act), .spd_in(spd), .fdx_in(fdx),
    .ind_n_out(ind_n), .spd_out(a_spd), .fdx_out(a_fdx));
  pms_mode_lamp #(.ADDR_W(12)) DUT (.mclk_in, .arst_n_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out,
    .pready_out, .pslverr_out, .link10_indicator_n_in(ind_n[0]),
    .full_duplex_indicator_n_in(ind_n[1]),
    .txrx_activity_indicator_n_in(ind_n[2]),
    .link100_indicator_n_in(ind_n[3]), .rx_activity_indicator_n_in(ind_n[4]),
    .tx_activity_indicator_n_in(ind_n[5]), .mac_autoneg_select_speed_100_in(a_spd),
    .mac_autoneg_select_full_duplex_in(a_fdx), .phy_speed_100_out, .phy_full_duplex_out,
    .phy_autoneg_mode_out, .first_lamp_output, .second_lamp_output);

  function automatic logic lamp(logic [2:0] c, logic [5:0] a);
    case (c)
      3'h0:    return a[3] | a[0];
      3'h2:    return a[0];
      3'h3:    return a[1];
      3'h4:    return a[2];
      3'h5:    return a[3];
      3'h6:    return a[4];
      3'h7:    return a[5];
      default: return 1'b0;
    endcase
  endfunction : lamp
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : wt
  // one transfer; waits on pready rather than assuming zero wait
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge mclk_in);
    psel_in    <= 1'b1;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    // no wait count assumed; the cycle ceiling ends a hang
    do begin
      @(posedge mclk_in);
    end while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic t_reset;
    apb(0, RPC, 32'h0);
    `CHK("rpc_rst", 32'h0, q)
    act <= 6'h08;
    wt(4);
    `CHK("lamp_a_rst", 1'b1, first_lamp_output)
    `CHK("lamp_b_rst", 1'b1, second_lamp_output)
  endtask : t_reset
  task automatic t_lamps;
    logic [2:0] c [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 7; i++) begin
      apb(1, RPC, {24'h0, c[i], c[6-i], 2'h0});
      for (int j = 0; j < 7; j++) begin
        act <= 6'(1 << j);
        wt(4);
        `CHK("lamp_a", lamp(c[i], act), first_lamp_output)
        `CHK("lamp_b", lamp(c[6-i], act), second_lamp_output)
      end
    end
  endtask : t_lamps
  // every manual row; don't-care bits set opposite to catch leaks
  task automatic t_mode;
    logic s, d;
    int r;
    for (int k = 0; k < 12; k++) begin
      s = k[0];
      d = k[1];
      r = k / 4;
      spd <= !s;
      fdx <= !d;
      apb(1, PHC, {18'h0, (r == 2) ~^ s, r == 1, 3'h0, (r == 2) ~^ d, 8'h0});
      apb(1, RPC, {18'h0, (r == 2) ^ s, (r == 2) ^ d, r == 2, 11'h0});
      wt(2);
      `CHK("speed", s, phy_speed_100_out)
      `CHK("duplex", d, phy_full_duplex_out)
      `CHK("neg_mode", 1'b0, phy_autoneg_mode_out)
    end
  endtask : t_mode
  task automatic t_neg;
    apb(1, PHC, 32'h00001000);
    for (int k = 0; k < 4; k++) begin
      spd <= k[0];
      fdx <= k[1];
      wt(4);
      `CHK("neg_mode", 1'b1, phy_autoneg_mode_out)
      `CHK("neg_speed", k[0], phy_speed_100_out)
      `CHK("neg_duplex", k[1], phy_full_duplex_out)
    end
    // negotiated, 100 Mbps full duplex, lamps dark, no indicator
    apb(0, STA, 32'h0);
    `CHK("stat_word", 32'h00000007, q)
    apb(1, PHC, 32'h0);
    wt(2);
    `CHK("neg_off", 1'b0, phy_autoneg_mode_out)
  endtask : t_neg
  // refusals: unmapped, misaligned, reserved bits
  task automatic t_bus;
    apb(0, 12'h030, 32'h0);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_rd", 32'h0, q)
    apb(0, 12'h029, 32'h0);
    `CHK("misalign_err", 1'b1, e)
    apb(1, RPC, 32'hFFFFFFFF);
    apb(0, RPC, 32'h0);
    `CHK("rpc_reserved", 32'h000038FC, q)
    // low lane only: upper byte must keep its bits
    pstrb_in <= 4'h1;
    apb(1, RPC, 32'h0);
    pstrb_in <= 4'hF;
    apb(0, RPC, 32'h0);
    `CHK("rpc_lane", 32'h00003800, q)
    apb(1, RPC, 32'h0);
  endtask : t_bus
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      close_out;
    end
  end
  initial begin
    arst_n_in  = 1'b0;
    psel_in    = 1'b0;
    penable_in = 1'b0;
    pwrite_in  = 1'b0;
    paddr_in   = 12'h000;
    pwdata_in  = 32'h0;
    pstrb_in   = 4'hF;
    act        = 6'h00;
    spd        = 1'b0;
    fdx        = 1'b0;
    repeat (4) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    t_reset;
    t_lamps;
    t_mode;
    t_neg;
    t_bus;
    close_out;
  end
endmodule : pms_mode_lamp_tb

// ==== bench/pms_phy_model.sv ====
// stand-in for the phy: indicator pins and negotiation outcome
// assumes the bench says which indicators are asserted
module pms_phy_model (
  input  wire logic [5:0] act_in,
  input  wire logic       spd_in,
  input  wire logic       fdx_in,
  output logic      [5:0] ind_n_out,
  output logic            spd_out,
  output logic            fdx_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // indicator pins are pulled low while asserted
  assign ind_n_out = ~act_in;
  assign spd_out   = spd_in;
  assign fdx_out   = fdx_in;
endmodule : pms_phy_model

// ==== verilog/pms_consts.svh ====
// register offsets, field positions and reset values of the mode/lamp block
// assumes inclusion by bare name from the package and the design modules
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define PMS_RPC_IDX        10'h00A
`define PMS_PHYC_IDX       10'h010
`define PMS_STAT_IDX       10'h011

// ****************************************************************
// receive_phy_control fields
// ****************************************************************
`define PMS_RPC_SPEED_BIT  13
`define PMS_RPC_DUPLEX_SELECT_BIT   12
`define PMS_RPC_MAC_AUTONEG_SELECT_BIT   11
`define PMS_RPC_LSA_HI     7
`define PMS_RPC_LSA_LO     5
`define PMS_RPC_LSB_HI     4
`define PMS_RPC_LSB_LO     2
`define PMS_RPC_RST        16'h0000
`define PMS_RPC_WMASK      16'h38FC

// ****************************************************************
// phy_control (register 0 of the internal phy) fields
// ****************************************************************
`define PMS_PHYC_SPEED_BIT 13
`define PMS_PHYC_NEG_BIT   12
`define PMS_PHYC_DUPLEX_SELECT_BIT  8
`define PMS_PHYC_RST       16'h3000
`define PMS_PHYC_WMASK     16'h3100

// ****************************************************************
// lamp select codes
// ****************************************************************
`define PMS_LS_ANY_LINK    3'h0
`define PMS_LS_RESERVED    3'h1
`define PMS_LS_LINK10      3'h2
`define PMS_LS_FULL_DUPLEX_SELECT   3'h3
`define PMS_LS_TXRX_ACT    3'h4
`define PMS_LS_LINK100     3'h5
`define PMS_LS_RX_ACT      3'h6
`define PMS_LS_TX_ACT      3'h7

`endif

// ==== verilog/pms_lamp_mux.sv ====
// one eight-way lamp source selector, purely combinational
// assumes indicator inputs are synchronised and active high
`include "pms_consts.svh"
module pms_lamp_mux
  import pms_pkg::*;
(
  // select
  input  wire pms_lamp_sel_t sel_in,
  // indicators, high while asserted
  input  wire logic          link10_in,
  input  wire logic          full_duplex_select_in,
  input  wire logic          txrx_act_in,
  input  wire logic          link100_in,
  input  wire logic          rx_act_in,
  input  wire logic          tx_act_in,
  // lamp level, high while lit
  output logic               lamp_out
);

  always_comb begin
    case (sel_in)
      `PMS_LS_ANY_LINK:  lamp_out = link100_in | link10_in;
      `PMS_LS_LINK10:    lamp_out = link10_in;
      `PMS_LS_FULL_DUPLEX_SELECT: lamp_out = full_duplex_select_in;
      `PMS_LS_LINK100:   lamp_out = link100_in;
      `PMS_LS_TXRX_ACT:  lamp_out = txrx_act_in;
      `PMS_LS_RX_ACT:    lamp_out = rx_act_in;
      `PMS_LS_TX_ACT:    lamp_out = tx_act_in;
      // reserved code keeps the lamp dark
      default:           lamp_out = 1'b0;
    endcase
  end

endmodule : pms_lamp_mux

// ==== verilog/pms_mode_lamp.sv ====
// phy speed/duplex mode resolution and two lamp selectors behind APB
// assumes a single 25 MHz clock; indicators and negotiation outcome
// come from the phy and are treated as asynchronous
`include "pms_consts.svh"

module pms_mode_lamp
  import pms_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              arst_n_in,
  // apb slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // phy indicators, low while asserted
  input  wire logic              link10_indicator_n_in,
  input  wire logic              full_duplex_indicator_n_in,
  input  wire logic              txrx_activity_indicator_n_in,
  input  wire logic              link100_indicator_n_in,
  input  wire logic              rx_activity_indicator_n_in,
  input  wire logic              tx_activity_indicator_n_in,
  // negotiation outcome
  input  wire logic              mac_autoneg_select_speed_100_in,
  input  wire logic              mac_autoneg_select_full_duplex_in,
  // phy mode
  output logic                   phy_speed_100_out,
  output logic                   phy_full_duplex_out,
  output logic                   phy_autoneg_mode_out,
  // lamps, high while lit
  output logic                   first_lamp_output,
  output logic                   second_lamp_output
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [9:0]        idx);
    logic [ADDR_W-1:0] byte_addr;
    byte_addr = ADDR_W'({idx, 2'b00});
    reg_hit   = (addr == byte_addr);
  endfunction : reg_hit

  // only writable bits in enabled byte lanes change
  function automatic logic [15:0] merge_write(input logic [15:0] old,
                                              input logic [15:0] data,
                                              input logic [1:0]  strb,
                                              input logic [15:0] wmask);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    merge_write = (old & ~m) | (data & m);
  endfunction : merge_write

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [7:0] sync_q1_r;
  logic [7:0] sync_q2_r;
  logic [7:0] sync_raw;

  assign sync_raw = {mac_autoneg_select_full_duplex_in,
                     mac_autoneg_select_speed_100_in,
                     tx_activity_indicator_n_in,
                     rx_activity_indicator_n_in,
                     link100_indicator_n_in,
                     txrx_activity_indicator_n_in,
                     full_duplex_indicator_n_in,
                     link10_indicator_n_in};

  // indicator stages reset to "not asserted"
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_q1_r <= 8'h3F;
      sync_q2_r <= 8'h3F;
    end else begin
      sync_q1_r <= sync_raw;
      sync_q2_r <= sync_q1_r;
    end
  end

  logic       ind_link10;
  logic       ind_full_duplex_select;
  logic       ind_txrx_act;
  logic       ind_link100;
  logic       ind_rx_act;
  logic       ind_tx_act;
  logic       neg_speed_100;
  logic       neg_full_duplex_select;

  assign ind_link10    = ~sync_q2_r[0];
  assign ind_full_duplex_select = ~sync_q2_r[1];
  assign ind_txrx_act  = ~sync_q2_r[2];
  assign ind_link100   = ~sync_q2_r[3];
  assign ind_rx_act    = ~sync_q2_r[4];
  assign ind_tx_act    = ~sync_q2_r[5];
  assign neg_speed_100 = sync_q2_r[6];
  assign neg_full_duplex_select = sync_q2_r[7];

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic apb_setup;
  logic apb_access;
  logic hit_rpc;
  logic hit_phyc;
  logic hit_stat;
  logic hit_any;
  logic wr_rpc;
  logic wr_phyc;

  assign apb_setup  = psel_in & ~penable_in;
  assign apb_access = psel_in & penable_in;
  assign hit_rpc    = reg_hit(paddr_in, `PMS_RPC_IDX);
  assign hit_phyc   = reg_hit(paddr_in, `PMS_PHYC_IDX);
  assign hit_stat   = reg_hit(paddr_in, `PMS_STAT_IDX);
  assign hit_any    = hit_rpc | hit_phyc | hit_stat;
  assign wr_rpc     = apb_access & pwrite_in & hit_rpc;
  assign wr_phyc    = apb_access & pwrite_in & hit_phyc;

  // zero wait states: every access phase completes at once
  assign pready_out  = 1'b1;
  assign pslverr_out = apb_access & ~hit_any;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [15:0] rpc_r;
  logic [15:0] phyc_r;

  // reserved bits never store, so they read back as zero
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rpc_r <= `PMS_RPC_RST;
    end else if (wr_rpc) begin
      rpc_r <= merge_write(rpc_r, pwdata_in[15:0], pstrb_in[1:0],
                           `PMS_RPC_WMASK);
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phyc_r <= `PMS_PHYC_RST;
    end else if (wr_phyc) begin
      phyc_r <= merge_write(phyc_r, pwdata_in[15:0], pstrb_in[1:0],
                            `PMS_PHYC_WMASK);
    end
  end

  logic          mac_autoneg_select;
  logic          mac_speed_select;
  logic          mac_duplex_select;
  logic          phy_negotiation_enable;
  logic          phy_speed_select;
  logic          phy_duplex_select;
  pms_lamp_sel_t led_a_select;
  pms_lamp_sel_t led_b_select;

  assign mac_autoneg_select     = rpc_r[`PMS_RPC_MAC_AUTONEG_SELECT_BIT];
  assign mac_speed_select       = rpc_r[`PMS_RPC_SPEED_BIT];
  assign mac_duplex_select      = rpc_r[`PMS_RPC_DUPLEX_SELECT_BIT];
  assign phy_negotiation_enable = phyc_r[`PMS_PHYC_NEG_BIT];
  assign phy_speed_select       = phyc_r[`PMS_PHYC_SPEED_BIT];
  assign phy_duplex_select      = phyc_r[`PMS_PHYC_DUPLEX_SELECT_BIT];
  assign led_a_select = rpc_r[`PMS_RPC_LSA_HI:`PMS_RPC_LSA_LO];
  assign led_b_select = rpc_r[`PMS_RPC_LSB_HI:`PMS_RPC_LSB_LO];

  // ****************************************************************
  // mode resolution
  // ****************************************************************
  pms_mode_t mode_nxt;
  pms_mode_t mode_r;
  logic      speed_nxt;
  logic      duplex_select_nxt;
  logic      speed_r;
  logic      duplex_select_r;

  always_comb begin
    if (!mac_autoneg_select) begin
      mode_nxt = PMS_MODE_MAC_MANUAL;
    end else if (!phy_negotiation_enable) begin
      mode_nxt = PMS_MODE_PHY_MANUAL;
    end else begin
      mode_nxt = PMS_MODE_AUTONEG;
    end
  end

  // a set bit means 100 Mbps or full duplex
  always_comb begin
    case (mode_nxt)
      PMS_MODE_MAC_MANUAL: begin
        speed_nxt = mac_speed_select;
        duplex_select_nxt  = mac_duplex_select;
      end
      PMS_MODE_PHY_MANUAL: begin
        speed_nxt = phy_speed_select;
        duplex_select_nxt  = phy_duplex_select;
      end
      PMS_MODE_AUTONEG: begin
        speed_nxt = neg_speed_100;
        duplex_select_nxt  = neg_full_duplex_select;
      end
      default: begin
        speed_nxt = 1'b0;
        duplex_select_nxt  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode_r  <= PMS_MODE_MAC_MANUAL;
      speed_r <= 1'b0;
      duplex_select_r  <= 1'b0;
    end else begin
      mode_r  <= mode_nxt;
      speed_r <= speed_nxt;
      duplex_select_r  <= duplex_select_nxt;
    end
  end

  assign phy_speed_100_out    = speed_r;
  assign phy_full_duplex_out  = duplex_select_r;
  assign phy_autoneg_mode_out = (mode_r == PMS_MODE_AUTONEG);

  // ****************************************************************
  // lamps
  // ****************************************************************
  logic lamp_a;
  logic lamp_b;
  logic lamp_a_r;
  logic lamp_b_r;

  pms_lamp_mux u_lamp_a (
    .sel_in       (led_a_select),
    .link10_in    (ind_link10),
    .full_duplex_select_in (ind_full_duplex_select),
    .txrx_act_in  (ind_txrx_act),
    .link100_in   (ind_link100),
    .rx_act_in    (ind_rx_act),
    .tx_act_in    (ind_tx_act),
    .lamp_out     (lamp_a)
  );

  pms_lamp_mux u_lamp_b (
    .sel_in       (led_b_select),
    .link10_in    (ind_link10),
    .full_duplex_select_in (ind_full_duplex_select),
    .txrx_act_in  (ind_txrx_act),
    .link100_in   (ind_link100),
    .rx_act_in    (ind_rx_act),
    .tx_act_in    (ind_tx_act),
    .lamp_out     (lamp_b)
  );

  // one flop keeps the pins glitch free while the select changes
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lamp_a_r <= 1'b0;
      lamp_b_r <= 1'b0;
    end else begin
      lamp_a_r <= lamp_a;
      lamp_b_r <= lamp_b;
    end
  end

  assign first_lamp_output  = lamp_a_r;
  assign second_lamp_output = lamp_b_r;

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [15:0] stat_word;
  logic [31:0] rd_nxt;
  logic [31:0] prdata_r;

  assign stat_word = {5'h00,
                      ind_tx_act, ind_rx_act, ind_link100,
                      ind_txrx_act, ind_full_duplex_select, ind_link10,
                      lamp_b_r, lamp_a_r,
                      duplex_select_r, speed_r,
                      (mode_r == PMS_MODE_AUTONEG)};

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit_rpc) begin
      rd_nxt = {16'h0000, rpc_r};
    end else if (hit_phyc) begin
      rd_nxt = {16'h0000, phyc_r};
    end else if (hit_stat) begin
      rd_nxt = {16'h0000, stat_word};
    end
  end

  // sampled in the setup cycle, held through the access phase
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_r <= 32'h0000_0000;
    end else if (apb_setup && !pwrite_in) begin
      prdata_r <= rd_nxt;
    end
  end

  assign prdata_out = prdata_r;

endmodule : pms_mode_lamp

// ==== verilog/pms_pkg.sv ====
// types shared by the mode/lamp block
// assumes pms_consts.svh is on the include path
package pms_pkg;
  `include "pms_consts.svh"

  // gray order: mac manual -> phy manual -> negotiated
  typedef enum logic [1:0] {
    PMS_MODE_MAC_MANUAL = 2'h0,
    PMS_MODE_PHY_MANUAL = 2'h1,
    PMS_MODE_AUTONEG    = 2'h3
  } pms_mode_t;

  typedef logic [2:0] pms_lamp_sel_t;
endpackage : pms_pkg
